// ---- rtl/asa_params.svh ----
// Register offsets, field positions, reset values for the alarm aggregator
`ifndef ASA_PARAMS_SVH
`define ASA_PARAMS_SVH
`define ASA_OFS_SUMMARY 10'h2c0
`define ASA_OFS_FLAGS 10'h2c1
`define ASA_OFS_DISABLE 10'h2c2
`define ASA_OFS_LANES 10'h2c4
`define ASA_BIT_FIFO 5
`define ASA_BIT_SPLL 4
`define ASA_BIT_LINK 3
`define ASA_BIT_REALIGN 2
`define ASA_BIT_RSVD1 1
`define ASA_BIT_CLK 0
`define ASA_FLAGS_RST 8'h3f
`define ASA_DISABLE_RST 8'h3f
`define ASA_LANES_RST 8'hff
`define ASA_ALARM_MASK 8'h3d
`define ASA_SEL_ALARM 2'h1
`endif

// ---- rtl/asa_pkg.sv ----
// Types shared by the alarm aggregator modules
package asa_pkg;
   typedef enum logic {ASA_ENC_8B10B, ASA_ENC_64B66B} asa_enc_t;
   typedef logic [7:0] asa_byte_t;
endpackage

// ---- rtl/asa_evt_if.sv ----
// Alarm event signals passed from the condition detector to the register file
`timescale 1ns/10ps
`default_nettype none
interface asa_evt_if;
   logic [7:0] set_flags;
   logic [7:0] set_lanes;
   modport src (output set_flags, output set_lanes);
   modport dst (input set_flags, input set_lanes);
endinterface
`default_nettype wire

// ---- rtl/asa_detect.sv ----
// Turns synchronised alarm conditions into per-cycle set requests
`timescale 1ns/10ps
`default_nettype none
`include "asa_params.svh"
module asa_detect
   import asa_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Synchronised conditions
   input wire logic link_en,
   input wire asa_enc_t enc_mode,
   input wire logic link_in_data,
   input wire logic realign_evt,
   input wire logic pll_locked,
   input wire logic sysref_realign,
   input wire logic div_mismatch,
   input wire logic [7:0] lane_fault,
   // Set requests
   asa_evt_if.src evt
);
   logic link_en_r, link_en_nxt;

   // Previous link enable, for the start-up edge
   always_comb begin
      link_en_nxt = link_en;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         link_en_r <= 1'b0;
      end else begin
         link_en_r <= link_en_nxt;
      end
   end

   // Conditions that set each flag
   always_comb begin
      evt.set_flags = 8'h00;
      evt.set_lanes = lane_fault;
      evt.set_flags[`ASA_BIT_FIFO] = |lane_fault;
      evt.set_flags[`ASA_BIT_SPLL] = ~pll_locked;
      if (enc_mode == ASA_ENC_8B10B) begin
         evt.set_flags[`ASA_BIT_LINK] = link_en & ~link_in_data;
      end else begin
         evt.set_flags[`ASA_BIT_LINK] = link_en & (~link_en_r | realign_evt);
      end
      evt.set_flags[`ASA_BIT_REALIGN] = sysref_realign;
      evt.set_flags[`ASA_BIT_CLK] = div_mismatch;
   end
endmodule
`default_nettype wire

// ---- rtl/asa_alarm_top.sv ----
// Alarm status aggregator: sticky flags, disable mask, summary and pin output
`timescale 1ns/10ps
`default_nettype none
`include "asa_params.svh"
// How it works
// - Summary bit 0 reads one when any flag other than reserved bit 1 is set and not disabled.
// - Each alarm has its own disable bit keeping it out of the summary.
// - Selector can route the summary onto the status output pin.
// - Flag bit 5 sets on any active lane FIFO overflow or underflow.
// - Per-lane register records which lanes caused the FIFO alarm.
// - Flag bit 4 sets while the serializer PLL is unlocked.
// - 8B/10B: flag bit 3 sets when link enabled but not transmitting data.
// - 64B/66B: flag bit 3 sets at link start and on each realignment.
// - Flag bit 2 sets when a realign event realigns internal clocks.
// - Flag bit 0 sets when AB and CD clock dividers disagree.
// - Writing one to a flag bit clears it.
// - Reset sets the flags register to 0x3f.
// - With link disabled, all but the clock flag are undefined; clear after enabling.
// - Summary register is read-only, bits 7:1 read zero.
// - Disable bits share flag positions and reset to one.
// - Lane bit i sets on lane i fault; write one clears; flag 5 clear clears all.
module asa_alarm_top
   import asa_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Register port
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Link state from the serial link, same clock
   input wire logic serial_link_enable,
   input wire asa_enc_t enc_mode,
   input wire logic data_transmission_state,
   input wire logic link_realign_evt,
   input wire logic sysref_realign,
   input wire logic [7:0] lane_fault,
   // Conditions from other domains
   input wire logic pll_locked,
   input wire logic div_mismatch,
   // Status pin
   input wire logic [1:0] status_pin_sel,
   input wire logic status_pin_other,
   output logic status_output_pin
);
   asa_evt_if evt ();
   asa_byte_t flags_r, flags_nxt, dis_r, dis_nxt, lanes_r, lanes_nxt, rdata_r, rdata_nxt;
   logic [1:0] pll_sync_r, pll_sync_nxt, div_sync_r, div_sync_nxt;
   logic summary;
   logic wr_flags, wr_dis, wr_lanes;

   // Two-stage synchronisers for the PLL lock and divider compare
   // They reset to unlocked, so the unlock flag holds until the chain fills
   always_comb begin
      pll_sync_nxt = {pll_sync_r[0], pll_locked};
      div_sync_nxt = {div_sync_r[0], div_mismatch};
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pll_sync_r <= 2'h0;
         div_sync_r <= 2'h0;
      end else begin
         pll_sync_r <= pll_sync_nxt;
         div_sync_r <= div_sync_nxt;
      end
   end

   asa_detect u_detect (
      .clk(clk),
      .sys_rst(sys_rst),
      .link_en(serial_link_enable),
      .enc_mode(enc_mode),
      .link_in_data(data_transmission_state),
      .realign_evt(link_realign_evt),
      .pll_locked(pll_sync_r[1]),
      .sysref_realign(sysref_realign),
      .div_mismatch(div_sync_r[1]),
      .lane_fault(lane_fault),
      .evt(evt)
   );

   assign wr_flags = reg_wr && (reg_addr == `ASA_OFS_FLAGS);
   assign wr_dis = reg_wr && (reg_addr == `ASA_OFS_DISABLE);
   assign wr_lanes = reg_wr && (reg_addr == `ASA_OFS_LANES);

   // Sets are merged last so that a lasting condition survives its own clear
   // Condition sets never reach bits 7:6 or the reserved bit 1; only reset loads bit 1 to one
   // Sticky flags: write-one clears, a set in the same cycle wins
   always_comb begin
      flags_nxt = flags_r;
      lanes_nxt = lanes_r;
      dis_nxt = dis_r;
      if (wr_flags) begin
         flags_nxt = flags_r & ~reg_wdata;
         if (reg_wdata[`ASA_BIT_FIFO]) begin
            lanes_nxt = 8'h00;
         end
      end
      if (wr_lanes) begin
         lanes_nxt = lanes_r & ~reg_wdata;
      end
      if (wr_dis) begin
         dis_nxt = reg_wdata;
      end
      flags_nxt = flags_nxt | (evt.set_flags & `ASA_ALARM_MASK);
      lanes_nxt = lanes_nxt | evt.set_lanes;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         flags_r <= `ASA_FLAGS_RST;
         dis_r <= `ASA_DISABLE_RST;
         lanes_r <= `ASA_LANES_RST;
      end else begin
         flags_r <= flags_nxt;
         dis_r <= dis_nxt;
         lanes_r <= lanes_nxt;
      end
   end

   // Summary of unmasked alarms
   assign summary = |(flags_r & ~dis_r & `ASA_ALARM_MASK);

   // Unmapped addresses read zero; the last read value holds between reads
   // Read data register; summary register is read-only
   always_comb begin
      rdata_nxt = rdata_r;
      if (reg_rd) begin
         unique case (reg_addr)
            `ASA_OFS_SUMMARY: rdata_nxt = {7'h00, summary};
            `ASA_OFS_FLAGS: rdata_nxt = flags_r;
            `ASA_OFS_DISABLE: rdata_nxt = dis_r;
            `ASA_OFS_LANES: rdata_nxt = lanes_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= rdata_nxt;
      end
   end
   assign reg_rdata = rdata_r;

   // Registering costs one cycle of delay but keeps the pin free of glitches
   // Status pin mux, registered
   logic pin_r, pin_nxt;
   always_comb begin
      pin_nxt = (status_pin_sel == `ASA_SEL_ALARM) ? summary : status_pin_other;
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_r <= 1'b0;
      end else begin
         pin_r <= pin_nxt;
      end
   end
   assign status_output_pin = pin_r;

   // Checks on the register port
   summary_read_a: assert property (@(posedge clk) disable iff (sys_rst)
      (reg_rd && reg_addr == `ASA_OFS_SUMMARY) |=> reg_rdata == {7'h00, $past(summary)})
      else $error("summary read wrong");
   dis_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      wr_dis |=> dis_r == $past(reg_wdata))
      else $error("disable write lost");

   // Checks on the summary and the pin
   summary_mask_a: assert property (@(posedge clk) disable iff (sys_rst)
      summary == ((flags_r[`ASA_BIT_FIFO] & ~dis_r[`ASA_BIT_FIFO]) | (flags_r[`ASA_BIT_SPLL] & ~dis_r[`ASA_BIT_SPLL])
         | (flags_r[`ASA_BIT_LINK] & ~dis_r[`ASA_BIT_LINK]) | (flags_r[`ASA_BIT_REALIGN] & ~dis_r[`ASA_BIT_REALIGN])
         | (flags_r[`ASA_BIT_CLK] & ~dis_r[`ASA_BIT_CLK]))) else $error("summary mismatch");
   summary_off_a: assert property (@(posedge clk) disable iff (sys_rst)
      (dis_r == `ASA_DISABLE_RST) |-> !summary)
      else $error("disabled alarm reached summary");
   pin_route_a: assert property (@(posedge clk) disable iff (sys_rst)
      (status_pin_sel == `ASA_SEL_ALARM) |=> status_output_pin == $past(summary))
      else $error("pin not routed");
   pin_other_a: assert property (@(posedge clk) disable iff (sys_rst)
      (status_pin_sel != `ASA_SEL_ALARM) |=> status_output_pin == $past(status_pin_other))
      else $error("pin other source lost");

   // Checks on each alarm source setting its flag
   fifo_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      (|lane_fault) |=> flags_r[`ASA_BIT_FIFO] && ((lanes_r & $past(lane_fault)) == $past(lane_fault)))
      else $error("fifo flag missed");
   pll_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      (!pll_sync_r[1]) |=> flags_r[`ASA_BIT_SPLL])
      else $error("pll flag missed");
   link_8b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (enc_mode == ASA_ENC_8B10B && serial_link_enable && !data_transmission_state)
      |=> flags_r[`ASA_BIT_LINK])
      else $error("link flag missed");
   link_64b_a: assert property (@(posedge clk) disable iff (sys_rst)
      (enc_mode == ASA_ENC_64B66B && serial_link_enable && (link_realign_evt || $rose(serial_link_enable)))
      |=> flags_r[`ASA_BIT_LINK])
      else $error("link start flag missed");
   realign_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      sysref_realign |=> flags_r[`ASA_BIT_REALIGN])
      else $error("realign flag missed");
   clk_set_a: assert property (@(posedge clk) disable iff (sys_rst)
      div_sync_r[1] |=> flags_r[`ASA_BIT_CLK])
      else $error("clock flag missed");

   // Checks on write-one clearing
   w1c_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_flags && reg_wdata[`ASA_BIT_REALIGN] && !sysref_realign) |=> !flags_r[`ASA_BIT_REALIGN])
      else $error("clear failed");
   zero_write_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_flags && reg_wdata == 8'h00) |=> (flags_r & $past(flags_r)) == $past(flags_r))
      else $error("zero write cleared");
   lane_clear_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_flags && reg_wdata[`ASA_BIT_FIFO] && lane_fault == 8'h00) |=> lanes_r == 8'h00)
      else $error("lanes not cleared");
   lane_w1c_a: assert property (@(posedge clk) disable iff (sys_rst)
      (wr_lanes && lane_fault == 8'h00) |=> (lanes_r & $past(reg_wdata)) == 8'h00)
      else $error("lane clear failed");
endmodule
`default_nettype wire

// ---- sim/tb_asa_alarm_top.sv ----
// Self-checking bench for the alarm status aggregator
`timescale 1ns/10ps
`default_nettype none
`include "asa_params.svh"
module tb_asa_alarm_top import asa_pkg::*; ;
   logic clk, sys_rst, reg_wr, reg_rd, serial_link_enable, data_transmission_state;
   logic link_realign_evt, sysref_realign, pll_locked, div_mismatch, status_pin_other, status_output_pin;
   logic [9:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, lane_fault;
   logic [1:0] status_pin_sel;
   asa_enc_t enc_mode;
   int err_total, total_checks, cycles;
   int bits [5] = '{`ASA_BIT_FIFO, `ASA_BIT_SPLL, `ASA_BIT_LINK, `ASA_BIT_REALIGN, `ASA_BIT_CLK};
   asa_byte_t rv, m, w, b;

   asa_alarm_top i_dut (.clk(clk), .sys_rst(sys_rst), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .serial_link_enable(serial_link_enable),
      .enc_mode(enc_mode), .data_transmission_state(data_transmission_state),
      .link_realign_evt(link_realign_evt), .sysref_realign(sysref_realign), .lane_fault(lane_fault),
      .pll_locked(pll_locked), .div_mismatch(div_mismatch), .status_pin_sel(status_pin_sel),
      .status_pin_other(status_pin_other), .status_output_pin(status_output_pin));

   // 200 MHz clock
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Expected summary for given flags and disable bits
   function automatic asa_byte_t summ(input asa_byte_t f, input asa_byte_t d);
      return {7'h00, |(f & ~d & `ASA_ALARM_MASK)};
   endfunction

   task automatic chk(input asa_byte_t seen, input asa_byte_t exp);
      total_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Register write, strobe held for one sampling edge, then one idle cycle
   task automatic wr(input logic [9:0] a, input asa_byte_t d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      cyc(1);
      reg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic rd(input logic [9:0] a, output asa_byte_t d);
      reg_rd = 1'b1;
      reg_addr = a;
      cyc(1);
      reg_rd = 1'b0;
      d = reg_rdata;
      cyc(1);
   endtask

   // Drive the condition behind one alarm
   task automatic cond(input int i, input logic v);
      case (i)
         0: lane_fault = v ? m : 8'h00;
         1: pll_locked = ~v;
         2: data_transmission_state = ~v;
         3: sysref_realign = v;
         default: div_mismatch = v;
      endcase
   endtask

   task automatic conclude();
      $display("Checks %0d, mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         err_total++;
         $display("Error at %0t: timeout", $time);
         conclude();
      end
   end

   initial begin
      {sys_rst, reg_wr, reg_rd, reg_addr, reg_wdata, lane_fault} = {3'b100, 10'h000, 16'h0000};
      {serial_link_enable, data_transmission_state, pll_locked, div_mismatch} = 4'b1110;
      {link_realign_evt, sysref_realign, status_pin_sel, status_pin_other} = 5'b00010;
      enc_mode = ASA_ENC_8B10B;
      void'($urandom(71294));
      repeat (6) @(posedge clk);
      #1 sys_rst = 1'b0;
      chk({7'h00, status_output_pin}, 8'h00);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, `ASA_FLAGS_RST);
      rd(`ASA_OFS_DISABLE, rv); chk(rv, 8'h3f);
      rd(`ASA_OFS_LANES, rv); chk(rv, 8'hff);
      wr(`ASA_OFS_SUMMARY, 8'hff);
      rd(`ASA_OFS_SUMMARY, rv); chk(rv, 8'h00);
      rd(10'h2c3, rv); chk(rv, 8'h00);
      wr(`ASA_OFS_FLAGS, 8'h00);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h3f);
      wr(`ASA_OFS_FLAGS, 8'hff);
      wr(`ASA_OFS_LANES, 8'hff);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h00);
      rd(`ASA_OFS_LANES, rv); chk(rv, 8'h00);
      $display("Test reset and clear done");
      // One pass per alarm: set, summary through disable, pin routing, clear
      for (int i = 0; i < 5; i++) begin
         b = 8'h01 << bits[i];
         m = 8'($urandom_range(1, 255));
         status_pin_other = 1'($urandom);
         status_pin_sel = `ASA_SEL_ALARM;
         cond(i, 1'b1); cyc(2); cond(i, 1'b0); cyc(4);
         rd(`ASA_OFS_FLAGS, rv); chk(rv, b);
         if (i == 0) begin
            w = 8'($urandom);
            rd(`ASA_OFS_LANES, rv); chk(rv, m);
            wr(`ASA_OFS_LANES, w);
            rd(`ASA_OFS_LANES, rv); chk(rv, m & ~w);
         end
         wr(`ASA_OFS_DISABLE, 8'h3f & ~b); cyc(3);
         rd(`ASA_OFS_SUMMARY, rv); chk(rv, summ(b, 8'h3f & ~b));
         chk({7'h00, status_output_pin}, 8'h01);
         wr(`ASA_OFS_DISABLE, 8'h3f); cyc(3);
         rd(`ASA_OFS_SUMMARY, rv); chk(rv, summ(b, 8'h3f));
         status_pin_sel = 2'h0; cyc(3);
         chk({7'h00, status_output_pin}, {7'h00, status_pin_other});
         wr(`ASA_OFS_FLAGS, b);
         rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h00);
         rd(`ASA_OFS_LANES, rv); chk(rv, 8'h00);
      end
      $display("Test per-alarm done");
      // Lasting unlock sets its flag again straight after a clear
      pll_locked = 1'b0; cyc(4);
      wr(`ASA_OFS_FLAGS, 8'h10);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h10);
      pll_locked = 1'b1; cyc(4);
      wr(`ASA_OFS_FLAGS, 8'h10);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h00);
      $display("Test persistence done");
      // 64B/66B: no data-state check, flag on realign and on link start
      enc_mode = ASA_ENC_64B66B;
      data_transmission_state = 1'b0; cyc(2);
      wr(`ASA_OFS_FLAGS, 8'h08);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h00);
      link_realign_evt = 1'b1; cyc(1); link_realign_evt = 1'b0; cyc(2);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h08);
      serial_link_enable = 1'b0; cyc(3); serial_link_enable = 1'b1; cyc(1);
      wr(`ASA_OFS_FLAGS, 8'h37);
      rd(`ASA_OFS_FLAGS, rv); chk(rv & 8'h08, 8'h08);
      wr(`ASA_OFS_FLAGS, 8'h3f);
      rd(`ASA_OFS_FLAGS, rv); chk(rv, 8'h00);
      $display("Test 64b66b done");
      conclude();
   end
endmodule
`default_nettype wire
